// >>> testbench/spihfc_host.sv
// Host-side model of the serial link master
`timescale 1ns/1ps
module spihfc_host (
  input wire logic sys_clk_in,
  input wire logic miso_in,
  input wire logic ready_in,
  output logic sel_n_out,
  output logic sclk_out,
  output logic mosi_out
);
  // Idle: deselected, clock parked high
  initial begin
    sel_n_out = 1'h1;
    sclk_out = 1'h1;
    mosi_out = 1'h0;
  end
  // Half of the 48 ns link period
  task automatic half();
    repeat (6) @(negedge sys_clk_in);
  endtask
  // Paced host: no clock edge while the port is busy
  task automatic wait_ready();
    while (!ready_in) @(negedge sys_clk_in);
  endtask
  // Unpolled read: clock parked high for 2 us before the data byte
  task automatic gap();
    repeat (500) @(negedge sys_clk_in);
  endtask
  // Released MOSI flips so a stale level is never read
  task automatic frame(input logic on);
    sel_n_out = !on;
    if (!on) mosi_out = !mosi_out;
    half();
  endtask
  // MSB first, change on fall, sample on rise
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      sclk_out = 1'h0;
      mosi_out = tx[i];
      half();
      sclk_out = 1'h1;
      rx[i] = miso_in;
      half();
    end
  endtask
endmodule

// >>> testbench/spihfc_port_tb_top.sv
// Self-checking bench for the host port
`timescale 1ns/1ps
module spihfc_port_tb_top;
  logic sys_clk_in, rstn_in, sel_n, sclk, mosi, miso, oe, rdy, int_n, cv, rv, take;
  logic [7:0] status, cmd, rxd, tx_data, got, n_cmd, n_rx, n_take;
  logic tx_valid, is_read, stall, iclr;
  int err_total = 0, total_checks = 0, cyc = 0;
  // Core model keeps command_in_progress in this status bit
  localparam int unsigned CIP_POS = 1;
  `define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
  always #2 sys_clk_in = ~sys_clk_in;
  // Hang guard, well above the few thousand cycles needed
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // Core-side strobe counts; each strobe is one cycle wide
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      n_cmd <= 8'h00;
      n_rx <= 8'h00;
      n_take <= 8'h00;
    end else begin
      if (cv) n_cmd <= n_cmd + 8'h01;
      if (rv) n_rx <= n_rx + 8'h01;
      if (take) n_take <= n_take + 8'h01;
    end
  end
  spihfc_host host (.sys_clk_in(sys_clk_in), .miso_in(miso), .ready_in(rdy), .sel_n_out(sel_n), .sclk_out(sclk),
    .mosi_out(mosi));
  spihfc_port uut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .port_select_n_in(sel_n), .sclk_in(sclk),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(oe), .handshake_ready_out(rdy), .int_n_out(int_n),
    .status_in(status), .cmd_out(cmd), .cmd_valid_out(cv), .rx_data_out(rxd), .rx_valid_out(rv),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_take_out(take), .is_read_in(is_read),
    .buf_stall_in(stall), .int_clear_in(iclr));
  task automatic close_out();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic clear_int();
    iclr = 1'h1;
    host.half();
    iclr = 1'h0;
    `CHK(int_n, 1'h1)
  endtask
  // Status with ready overlay, then data and idle fill
  task automatic t_basic();
    host.frame(1'h1);
    host.xfer(8'h3C, 8, got);
    `CHK(got, 8'hA5)
    `CHK(cmd, 8'h3C)
    host.xfer(8'hC3, 8, got);
    `CHK(got, 8'h5A)
    `CHK(rxd, 8'hC3)
    tx_valid = 1'h0;
    host.xfer(8'h00, 8, got);
    `CHK(got, 8'hFF)
    `CHK({rdy, int_n}, 2'h3)
    host.frame(1'h0);
    `CHK(n_cmd, 8'h01)
    `CHK(n_rx, 8'h02)
    `CHK(n_take, 8'h01)
  endtask
  // Busy pacing, clocking while busy, recovery
  task automatic t_busy();
    stall = 1'h1;
    host.frame(1'h1);
    host.xfer(8'h12, 8, got);
    `CHK(rdy, 1'h0)
    host.xfer(8'h34, 8, got);
    `CHK(int_n, 1'h0)
    host.frame(1'h0);
    host.frame(1'h1);
    host.xfer(8'h56, 8, got);
    `CHK(got, 8'hA4)
    stall = 1'h0;
    host.half();
    `CHK(rdy, 1'h1)
    host.frame(1'h0);
    clear_int();
  endtask
  // Read with no data ready raises the interrupt
  task automatic t_invalid();
    is_read = 1'h1;
    host.frame(1'h1);
    host.xfer(8'h0F, 8, got);
    host.xfer(8'h00, 8, got);
    `CHK(int_n, 1'h0)
    host.frame(1'h0);
    is_read = 1'h0;
    clear_int();
  endtask
  // Idle clocking ignored, partial byte dropped
  task automatic t_ignore();
    host.xfer(8'hAA, 8, got);
    `CHK({oe, cmd}, 9'h00F)
    host.frame(1'h1);
    host.xfer(8'hF0, 4, got);
    host.frame(1'h0);
    host.frame(1'h1);
    host.xfer(8'h81, 8, got);
    `CHK(cmd, 8'h81)
    host.frame(1'h0);
  endtask
  // Unpolled read after an idle check, then a byte paced on ready
  task automatic t_paced();
    status = 8'h58;
    tx_data = 8'h3B;
    tx_valid = 1'h1;
    is_read = 1'h1;
    host.frame(1'h1);
    host.xfer(8'hD1, 8, got);
    `CHK(got, 8'h59)
    `CHK(got[CIP_POS], 1'h0)
    host.gap();
    stall = 1'h1;
    host.xfer(8'h00, 8, got);
    `CHK(got, 8'h3B)
    `CHK(rdy, 1'h0)
    tx_data = 8'hC6;
    fork
      host.wait_ready();
      begin
        repeat (20) @(negedge sys_clk_in);
        stall = 1'h0;
      end
    join
    host.xfer(8'h00, 8, got);
    `CHK(got, 8'hC6)
    `CHK(int_n, 1'h1)
    host.frame(1'h0);
    is_read = 1'h0;
  endtask
  initial begin
    sys_clk_in = 1'h0;
    rstn_in = 1'h0;
    status = 8'hA4;
    tx_data = 8'h5A;
    tx_valid = 1'h1;
    is_read = 1'h0;
    stall = 1'h0;
    iclr = 1'h0;
    repeat (5) @(negedge sys_clk_in);
    rstn_in = 1'h1;
    repeat (4) @(negedge sys_clk_in);
    `CHK({oe, miso, rdy, int_n}, 4'h3)
    t_basic();
    t_busy();
    t_invalid();
    t_ignore();
    t_paced();
    close_out();
  end
endmodule

// >>> testbench/spihfc_properties.sv
// Port-level timing checker for the host port
`timescale 1ns/1ps
module spihfc_properties (
  input wire logic sys_clk_in, rstn_in, port_select_n_in, miso_out, miso_oe_out, handshake_ready_out,
  input wire logic int_n_out, cmd_valid_out, rx_valid_out, buf_stall_in, int_clear_in
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // Frame start, then the port drives within the sync delay
  sequence sel_fall_s; $fell(port_select_n_in); endsequence
  sequence drive_s; ##[2:5] miso_oe_out; endsequence
  sel_drive_a: assert property (sel_fall_s |-> drive_s) else $error("no drive after select");
  sel_idle_a: assert property (port_select_n_in [*6] |-> !miso_oe_out) else $error("drive while idle");
  miso_park_a: assert property (!miso_oe_out |-> !miso_out) else $error("miso not parked");
  cmd_pulse_a: assert property (cmd_valid_out |-> !$past(port_select_n_in, 3) ##1 !cmd_valid_out)
    else $error("bad command strobe");
  busy_drop_a: assert property (cmd_valid_out && buf_stall_in |-> ##[0:2] !handshake_ready_out)
    else $error("ready did not drop");
  busy_hold_a: assert property (!handshake_ready_out ##1 buf_stall_in |-> !handshake_ready_out)
    else $error("ready rose early");
  int_hold_a: assert property (!int_n_out ##1 !int_clear_in |-> !int_n_out) else $error("int lost");
  int_clear_a: assert property (port_select_n_in [*6] ##0 int_clear_in |=> int_n_out)
    else $error("int not cleared");
  rx_frame_a: assert property (rx_valid_out |-> miso_oe_out) else $error("data outside frame");
endmodule
bind spihfc_port spihfc_properties u_props (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
  .port_select_n_in(port_select_n_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
  .handshake_ready_out(handshake_ready_out), .int_n_out(int_n_out), .cmd_valid_out(cmd_valid_out),
  .rx_valid_out(rx_valid_out), .buf_stall_in(buf_stall_in), .int_clear_in(int_clear_in));

// >>> verilog/spihfc_pins_if.sv
// Synchronised pin levels and edge strobes between sampler and port logic
`timescale 1ns/1ps
interface spihfc_pins_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_active;
  logic sel_fall;
  logic sel_rise;
  logic mosi_bit;
  modport sampler (output sclk_rise, output sclk_fall, output sel_active, output sel_fall, output sel_rise,
                   output mosi_bit);
  modport port (input sclk_rise, input sclk_fall, input sel_active, input sel_fall, input sel_rise,
                input mosi_bit);
endinterface

// >>> verilog/spihfc_pkg.sv
// Constants and types shared by the host-port flow-control block
package spihfc_pkg;
  // Byte framing on the serial link
  localparam int unsigned BYTE_W = 8;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Position of the ready flag inside the status byte
  localparam int unsigned STAT_RDY_POS = 0;
  // Bit count after which the ready flag is the next bit on MISO
  localparam logic [2:0] RDY_SLOT = 3'h7;
  // Byte sent when the core has no data ready
  localparam logic [7:0] IDLE_FILL = 8'hFF;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;
  // Transaction phase
  typedef enum logic [1:0] {
    SPIHFC_IDLE = 2'b00,
    SPIHFC_CMD = 2'b01,
    SPIHFC_DATA = 2'b10
  } spihfc_phase_t;
endpackage

// >>> verilog/spihfc_port.sv
// Serial host port of the playback device with ready/busy pacing
// Overview of operation
// - Mode 3 link: clock idles high, both sides sample on the rising clock edge.
// - A falling edge on the active-low select starts a new transaction and command.
// - While the command byte comes in, the status byte goes out on MISO bit for bit.
// - After the command, the port returns one data byte per eight clocks for as long as the host keeps clocking.
// - When a byte completes and the transfer buffer is full or empty, handshake_ready drops low.
// - Clocking while handshake_ready is low in the command byte, before the ready slot, clears the status ready bit sent on MISO.
// - The interrupt output goes low on write overrun or on invalid returned data.
`timescale 1ns/1ps
module spihfc_port (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Serial pins
  input wire logic port_select_n_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  output logic handshake_ready_out,
  output logic int_n_out,
  // Status from the device core, ready bit is overlaid here
  input wire logic [7:0] status_in,
  // Received command and data
  output logic [7:0] cmd_out,
  output logic cmd_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  // Data returned to the host
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_take_out,
  // Flow control and interrupt handling from the core
  input wire logic is_read_in,
  input wire logic buf_stall_in,
  input wire logic int_clear_in
);
  typedef struct packed {
    spihfc_pkg::spihfc_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic load_pend;
    logic hs_ready;
    logic rdy_lost;
    logic irq;
    logic [7:0] cmd;
    logic cmd_v;
    logic [7:0] rx;
    logic rx_v;
    logic take;
  } spihfc_port_st_t;

  spihfc_port_st_t st_ff;
  spihfc_port_st_t nxt_st;
  spihfc_pins_if pins ();

  // Pin sampling; the host clock is far slower than ours
  spihfc_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .port_select_n_in(port_select_n_in),
    .sclk_in(sclk_in),
    .mosi_in(mosi_in),
    .pins(pins)
  );

  // Status byte with the live ready flag in its slot
  function automatic logic [7:0] status_with_ready(input logic [7:0] stat, input logic rdy);
    logic [7:0] s;
    s = stat;
    s[spihfc_pkg::STAT_RDY_POS] = rdy;
    return s;
  endfunction

  // Transaction sequencing, shifting and flow control
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cmd_v = 1'b0;
    nxt_st.rx_v = 1'b0;
    nxt_st.take = 1'b0;
    // Clear first so a same-cycle error still raises the interrupt
    if (int_clear_in) begin
      nxt_st.irq = 1'b0;
    end
    // Ready returns once the core has room or data again
    if (!st_ff.hs_ready && !buf_stall_in) begin
      nxt_st.hs_ready = 1'b1;
    end
    if (pins.sel_fall) begin
      nxt_st.phase = spihfc_pkg::SPIHFC_CMD;
      nxt_st.bit_cnt = spihfc_pkg::BIT_FIRST;
      nxt_st.load_pend = 1'b0;
      nxt_st.rdy_lost = 1'b0;
      // MSB must sit on MISO before the first falling clock edge
      nxt_st.tx_sh = status_with_ready(status_in, st_ff.hs_ready);
    end else if (!pins.sel_active) begin
      nxt_st.phase = spihfc_pkg::SPIHFC_IDLE;
      nxt_st.bit_cnt = spihfc_pkg::BIT_FIRST;
      nxt_st.load_pend = 1'b0;
    end else if (st_ff.phase != spihfc_pkg::SPIHFC_IDLE) begin
      if (pins.sclk_rise) begin
        // Sample on the rising edge, MSB first
        nxt_st.rx_sh = {st_ff.rx_sh[6:0], pins.mosi_bit};
        nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
        // Clock while busy: overrun on writes, invalid data on reads
        if (!st_ff.hs_ready) begin
          nxt_st.rdy_lost = 1'b1;
          nxt_st.irq = 1'b1;
        end
        if (st_ff.bit_cnt == spihfc_pkg::BIT_LAST) begin
          nxt_st.load_pend = 1'b1;
          if (st_ff.phase == spihfc_pkg::SPIHFC_CMD) begin
            nxt_st.cmd = {st_ff.rx_sh[6:0], pins.mosi_bit};
            nxt_st.cmd_v = 1'b1;
            nxt_st.phase = spihfc_pkg::SPIHFC_DATA;
          end else begin
            nxt_st.rx = {st_ff.rx_sh[6:0], pins.mosi_bit};
            nxt_st.rx_v = 1'b1;
          end
          if (buf_stall_in) begin
            nxt_st.hs_ready = 1'b0;
          end
        end
      end
      if (pins.sclk_fall) begin
        if (st_ff.load_pend) begin
          nxt_st.load_pend = 1'b0;
          if (tx_valid_in) begin
            nxt_st.tx_sh = tx_data_in;
            nxt_st.take = 1'b1;
          end else begin
            nxt_st.tx_sh = spihfc_pkg::IDLE_FILL;
            // A read with nothing to give is invalid data
            if (is_read_in) begin
              nxt_st.irq = 1'b1;
            end
          end
        end else if (st_ff.phase != spihfc_pkg::SPIHFC_CMD || st_ff.bit_cnt != spihfc_pkg::BIT_FIRST) begin
          // Mode 3 shifts only after a sample, so the first fall of the command keeps S7 on MISO
          nxt_st.tx_sh = {st_ff.tx_sh[6:0], 1'b0};
          // Late busy violation still shows in the ready slot
          if (st_ff.phase == spihfc_pkg::SPIHFC_CMD && st_ff.bit_cnt == spihfc_pkg::RDY_SLOT &&
              (st_ff.rdy_lost || !st_ff.hs_ready)) begin
            nxt_st.tx_sh[7] = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st_ff <= '{phase: spihfc_pkg::SPIHFC_IDLE, bit_cnt: spihfc_pkg::BIT_FIRST, rx_sh: spihfc_pkg::BYTE_RST,
                 tx_sh: spihfc_pkg::BYTE_RST, load_pend: 1'b0, hs_ready: 1'b1, rdy_lost: 1'b0, irq: 1'b0,
                 cmd: spihfc_pkg::BYTE_RST, cmd_v: 1'b0, rx: spihfc_pkg::BYTE_RST, rx_v: 1'b0, take: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs, all taken from registered state
  assign miso_oe_out = (st_ff.phase != spihfc_pkg::SPIHFC_IDLE);
  assign miso_out = miso_oe_out & st_ff.tx_sh[7];
  assign handshake_ready_out = st_ff.hs_ready;
  assign int_n_out = ~st_ff.irq;
  assign cmd_out = st_ff.cmd;
  assign cmd_valid_out = st_ff.cmd_v;
  assign rx_data_out = st_ff.rx;
  assign rx_valid_out = st_ff.rx_v;
  assign tx_take_out = st_ff.take;
endmodule

// >>> verilog/spihfc_sync.sv
// Two-stage pin synchroniser with edge detection for clock and select
`timescale 1ns/1ps
module spihfc_sync (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Raw pins: {select_n, serial clock, mosi}
  input wire logic port_select_n_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  // Strobes toward the port logic
  spihfc_pins_if.sampler pins
);
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic sclk_prev;
    logic sel_n_prev;
  } spihfc_sync_st_t;

  spihfc_sync_st_t st_ff;
  spihfc_sync_st_t nxt_st;

  // Idle levels are high for both clock and select, so reset to that
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = {port_select_n_in, sclk_in, mosi_in};
    nxt_st.sync = st_ff.meta; // Only the second stage reads the first
    nxt_st.sclk_prev = st_ff.sync[1];
    nxt_st.sel_n_prev = st_ff.sync[2];
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st_ff <= '{meta: spihfc_pkg::SYNC_RST, sync: spihfc_pkg::SYNC_RST, sclk_prev: 1'b1, sel_n_prev: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Edges from the settled stage only
  assign pins.sclk_rise = st_ff.sync[1] & ~st_ff.sclk_prev;
  assign pins.sclk_fall = ~st_ff.sync[1] & st_ff.sclk_prev;
  assign pins.sel_fall = ~st_ff.sync[2] & st_ff.sel_n_prev;
  assign pins.sel_rise = st_ff.sync[2] & ~st_ff.sel_n_prev;
  assign pins.sel_active = ~st_ff.sync[2];
  assign pins.mosi_bit = st_ff.sync[0];
endmodule
